// File: inc/host_bus_pkg.sv
/*
  Shared constants and types of the host bus front end: widths, queue
  depth, decode windows, target and inbound source encodings.
  Assumes every block that includes it runs on the host bus clock.
*/
package host_bus_pkg;

  // ----------------------------------------------------------------
  // Widths and sizes
  // ----------------------------------------------------------------
  localparam int ADDR_W      = 36;          // 64 GB host address space
  localparam int LINE_BYTES  = 64;          // Coherent transfer unit
  localparam int LINE_LSB    = 6;           // log2 of the line size
  localparam int IOQ_DEPTH   = 8;           // Outstanding requests
  localparam int LANES       = 4;           // Data parity lanes
  localparam int LANE_W      = 16;          // Data bits per lane
  localparam int DATA_W      = LANES * LANE_W;
  localparam int MAX_AGENTS  = 2;           // Processors on the bus
  localparam int BUS_MHZ     = 100;         // Bus clock
  localparam int ADDR_XFERS  = 2;           // Address transfers per clock
  localparam int DATA_XFERS  = 4;           // Data transfers per clock
  localparam int MEM_RATIO   = 1;           // Host to memory data ratio

  // ----------------------------------------------------------------
  // Address parity split
  // ----------------------------------------------------------------
  localparam int AP0_LO = 3;                // Low parity group
  localparam int AP0_HI = 23;
  localparam int AP1_LO = 24;               // High parity group
  localparam int AP1_HI = 35;

  // ----------------------------------------------------------------
  // Decode windows (fixed; only MEM_TOP can be overridden at the top)
  // ----------------------------------------------------------------
  localparam logic [35:0] LIMIT_4G     = 36'h1_0000_0000;
  localparam logic [35:0] MEM_TOP      = 36'h0_4000_0000;
  localparam logic [35:0] GFX_MEM_BASE = 36'h0_E000_0000;
  localparam logic [35:0] GFX_MEM_LIM  = 36'h0_E7FF_FFFF;
  localparam logic [35:0] HUBB_MEM_BASE= 36'h0_E800_0000;
  localparam logic [35:0] HUBB_MEM_LIM = 36'h0_EBFF_FFFF;
  localparam logic [35:0] HUBC_MEM_BASE= 36'h0_EC00_0000;
  localparam logic [35:0] HUBC_MEM_LIM = 36'h0_EFFF_FFFF;
  localparam logic [35:0] APER_BASE    = 36'h0_D000_0000;
  localparam logic [35:0] APER_LIM     = 36'h0_DFFF_FFFF;
  localparam logic [15:0] GFX_IO_BASE  = 16'hC000;
  localparam logic [15:0] GFX_IO_LIM   = 16'hCFFF;
  localparam logic [15:0] HUBB_IO_BASE = 16'hD000;
  localparam logic [15:0] HUBB_IO_LIM  = 16'hDFFF;
  localparam logic [15:0] HUBC_IO_BASE = 16'hE000;
  localparam logic [15:0] HUBC_IO_LIM  = 16'hEFFF;
  localparam logic [15:0] CFG_IO_BASE  = 16'h0CF8;
  localparam logic [15:0] CFG_IO_LIM   = 16'h0CFF;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DEST_GFX, DEST_HUBB, DEST_HUBC, DEST_CFG, DEST_MEM, DEST_SOUTH,
    DEST_NONE
  } dest_t;

  typedef enum logic [1:0] {
    SRC_GFX_NATIVE, SRC_GFX_PCI, SRC_HUB
  } inb_src_t;

  localparam int ENTRY_W = ADDR_W + 3 + 1;  // Address, target, translate

endpackage

// File: verification/host_agent.sv
/* Processor agent model: codes host data beats with inversion and parity.
   Assumes the bench holds word and bad for a whole cycle. */
`timescale 1ns/1ns
`default_nettype none
module host_agent
  import host_bus_pkg::*;
(
  input  wire logic [DATA_W-1:0] word, // Plain beat
  input  wire logic [LANES-1:0]  bad,  // Lanes sent with broken parity
  output logic      [DATA_W-1:0] data, // Beat as on the wire
  output logic      [LANES-1:0]  inv,  // Inversion flags
  output logic      [LANES-1:0]  par   // Even lane parity
);
  // Dense lanes inverted, the opposite policy of the hub, for variety
  always_comb
  begin
    for (int i = 0; i < LANES; i++)
    begin
      inv[i] = $countones(word[16*i+:16]) > 8;
      data[16*i+:16] = word[16*i+:16] ^ {16{inv[i]}};
      par[i] = ^{data[16*i+:16], inv[i]} ^ bad[i];
    end
  end
endmodule
`default_nettype wire

// File: verification/host_bus_monitor.sv
/* Port checker of the host bus front end.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ns
`default_nettype none
module host_bus_monitor
  import host_bus_pkg::*;
(
  input wire logic clock, reset, req_ready, out_valid, out_ready,
  input wire logic [ADDR_W-1:0] out_addr,
  input wire logic rx_valid, rxd_valid, txd_valid,
  input wire logic [DATA_W-1:0] txd_data,
  input wire logic [LANES-1:0] tx_data_bus_inversion, tx_data_parity,
  input wire logic rsp_valid, rspd_valid, response_parity,
  input wire logic [2:0] rsp_code, rspd_code,
  input wire logic inb_valid, inb_done, inb_snoop,
  input wire logic [1:0] inb_src,
  input wire logic serr_message, data_perr_seen
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  a_rsp_parity: assert property (response_parity == ^rspd_code)
    else $error("response parity wrong");
  a_rsp_echo: assert property (rsp_valid |=> rspd_valid
    && rspd_code == $past(rsp_code)) else $error("response not echoed");
  a_rx_restore: assert property (rx_valid |=> rxd_valid)
    else $error("beat lost");
  a_tx_par: assert property (txd_valid |-> tx_data_parity[0] ==
    ^{txd_data[15:0], tx_data_bus_inversion[0]}) else $error("tx parity");
  a_tx_invert: assert property (tx_data_bus_inversion[1] && txd_valid
    |-> $countones(txd_data[31:16]) > 8) else $error("needless invert");
  a_inb_snoop: assert property (inb_valid |=> inb_done &&
    inb_snoop == ($past(inb_src) != 2'h0)) else $error("snoop wrong");
  a_perr_sticky: assert property (data_perr_seen |=> data_perr_seen)
    else $error("error flag lost");
  a_reset_quiet: assert property (disable iff (1'b0) reset |=>
    !req_ready && !serr_message && !out_valid) else $error("reset leak");
  a_out_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_addr)) else $error("request dropped");
  // Main scenarios reached
  c_serr: cover property (serr_message);
  c_stall: cover property (out_valid && !out_ready);
  c_nosnoop: cover property (inb_done && !inb_snoop);
endmodule
bind host_bus_decode_parity host_bus_monitor mon (.*);
`default_nettype wire

// File: verification/tb.sv
/* Self-checking bench of the host bus front end.
   Assumes the agent model drives received beats. */
`timescale 1ns/1ns
`default_nettype none
module tb
  import host_bus_pkg::*;
;
  logic clock, reset, cfg_write, cfg_data_msg_en, cfg_addr_msg_en;
  logic req_valid, req_is_io, req_ready, out_valid, out_translate, out_ready;
  logic rx_valid, rxd_valid, tx_valid, txd_valid, rsp_valid, rspd_valid;
  logic response_parity, inb_valid, inb_done, inb_snoop, inb_translate;
  logic serr_message, data_perr_seen, addr_perr_seen;
  logic [35:0] req_addr, out_addr, inb_addr;
  logic [2:0] out_dest, rsp_code, rspd_code;
  logic [1:0] host_addr_parity, inb_src;
  logic [63:0] rx_data, rxd_data, tx_data, txd_data, word;
  logic [3:0] rx_data_bus_inversion, host_data_parity, bad;
  logic [3:0] tx_data_bus_inversion, tx_data_parity;
  logic [67:0] q_rx[$], q_tx[$], q_rsp[$], q_inb[$], q_out[$];
  int miscompares, num_checks, cyc, nserr;
  host_bus_decode_parity DUT (.*);
  host_agent cpu (.word(word), .bad(bad), .data(rx_data),
    .inv(rx_data_bus_inversion), .par(host_data_parity));
  initial
  begin
    clock = 0;
    forever #50 clock = ~clock;
  end
  task tally_and_finish;
    if (miscompares == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [67:0] s,
                     input logic [67:0] e);
    num_checks++;
    if (s !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task tick;
    @(posedge clock);
    #1;
  endtask
  // Hold a request until taken; expected memory address is line aligned
  task req(input logic io, input logic [35:0] a, input logic [2:0] d,
           input logic t, input logic [1:0] e);
    logic ok;
    req_valid = 1;
    req_is_io = io;
    req_addr = a;
    host_addr_parity = {^a[35:24], ^{a[23:3], io}} ^ e;
    do begin ok = req_ready; tick; end while (ok !== 1);
    q_out.push_back({d, t, io ? a : {a[35:6], 6'h00}});
  endtask
  // Transmit coding: sparse lanes go out inverted
  function automatic logic [67:0] code(input logic [63:0] d);
    code = {4'h0, d};
    for (int i = 0; i < 4; i++)
      if ($countones(d[16*i+:16]) < 8) code[64+i] = 1;
    for (int i = 0; i < 4; i++)
      if (code[64+i]) code[16*i+:16] = ~d[16*i+:16];
  endfunction
  // Watcher: each result against the oldest note of its kind
  always @(posedge clock)
  begin
    cyc++;
    if (cyc > 3000) begin miscompares++; tally_and_finish; end
    if (serr_message === 1) nserr++;
    if (rxd_valid === 1) chk("rxd", rxd_data, q_rx.pop_front());
    if (txd_valid === 1) chk("txd", {tx_data_bus_inversion, txd_data},
      q_tx.pop_front());
    if (rspd_valid === 1) chk("rsp", {rspd_code, response_parity},
      q_rsp.pop_front());
    if (inb_done === 1) chk("inb", {inb_snoop, inb_translate},
      q_inb.pop_front());
    if (out_valid === 1 && out_ready === 1) chk("req",
      {out_dest, out_translate, out_addr}, q_out.pop_front());
  end
  initial
  begin
    void'($urandom(32'h8B38));
    {cfg_write, cfg_data_msg_en, cfg_addr_msg_en, req_valid, req_is_io} = '0;
    {rx_valid, tx_valid, rsp_valid, inb_valid, inb_src, rsp_code} = '0;
    {req_addr, host_addr_parity, inb_addr, word, tx_data, bad} = '0;
    out_ready = 1;
    reset = 1;
    repeat (10) @(posedge clock);
    #1 reset = 0;
    chk("rst", {req_ready, out_valid, serr_message, data_perr_seen}, 0);
    for (int i = 0; i < 8; i++)
    begin
      word = i ? {$urandom, $urandom} : 64'h00FF_FFFF_0000_0F0F;
      tx_data = i ? {$urandom, $urandom} : word;
      inb_addr = {4'h0, $urandom} & 36'h0_0FFF_FFC0 | (i > 2 ? APER_BASE : 0);
      {rx_valid, tx_valid, rsp_valid, inb_valid} = {3'h7, i < 6};
      rsp_code = i[2:0];
      inb_src = 2'(i % 3);
      q_rx.push_back(word);
      q_tx.push_back(code(tx_data));
      q_rsp.push_back({rsp_code, ^rsp_code});
      if (i < 6) q_inb.push_back({inb_src != 0, i > 2});
      tick;
    end
    {rx_valid, tx_valid, rsp_valid, inb_valid} = '0;
    for (int k = 0; k < 2; k++)
    begin
      {rx_valid, bad} = {1'b1, 4'h2};
      q_rx.push_back(word);
      tick;
      {rx_valid, bad, cfg_write, cfg_data_msg_en, cfg_addr_msg_en} = 8'h07;
      tick;
      cfg_write = 0;
      tick;
      chk("serr", {data_perr_seen, nserr[3:0]}, {1'b1, k[3:0]});
    end
    req(1, 36'h0_0000_C010, DEST_GFX, 0, 0);
    req(1, 36'h0_0000_D004, DEST_HUBB, 0, 0);
    req(1, 36'h0_0000_EFFC, DEST_HUBC, 0, 0);
    req(1, 36'h0_0000_0CF8, DEST_CFG, 0, 0);
    req(1, 36'h0_0000_0060, DEST_SOUTH, 0, 0);
    req(0, 36'h0_E000_0047, DEST_GFX, 0, 0);
    req(0, 36'h0_D000_1000, DEST_MEM, 1, 0);
    req(0, 36'h0_8000_0000, DEST_SOUTH, 0, 0);
    req(0, 36'h2_0000_0000, DEST_NONE, 0, 2'h1);
    out_ready = 0;
    // Stalled stage holds one and the queue one more: seven fill it
    for (int k = 0; k < 7; k++)
      req(0, {4'h0, $urandom} & 36'h0_3FFF_FFFF, DEST_MEM, 0, 0);
    req_valid = 0;
    repeat (2) tick;
    // Enabled address parity error adds the second message
    chk("full", {req_ready, nserr[3:0], addr_perr_seen}, 6'h05);
    out_ready = 1;
    repeat (20) tick;
    chk("drain", q_out.size() + q_rx.size() + q_tx.size()
      + q_rsp.size() + q_inb.size(), 0);
    tally_and_finish;
  end
endmodule
`default_nettype wire

// File: verilog/dbi_lane.sv
/*
  One 16-bit data lane: restores inverted receive data, codes transmit
  data with bus inversion, and computes even lane parity both ways.
  Assumes inputs are already on the host clock; purely combinational.
*/
`timescale 1ns/1ns
`default_nettype none
module dbi_lane
  import host_bus_pkg::*;
#(
  parameter int W = LANE_W
)(
  input  wire logic [W-1:0] rx_word,     // Word as seen on the bus
  input  wire logic         rx_inv,      // Sender inverted this lane
  input  wire logic         rx_par,      // Lane parity as received
  input  wire logic [W-1:0] tx_word,     // Word to send
  output logic      [W-1:0] rx_plain,    // Restored word
  output logic              rx_bad,      // Lane parity mismatch
  output logic      [W-1:0] tx_coded,    // Word as driven
  output logic              tx_inv,      // Inversion flag driven
  output logic              tx_par       // Parity driven
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (W < 2 || W > 64)
  begin : g_bad_w
    $error("dbi_lane width out of range");
  end

  // ----------------------------------------------------------------
  // Receive and transmit coding
  // ----------------------------------------------------------------
  // Invert when more than half the bits are low, so fewer lines switch
  always_comb
  begin
    rx_plain = rx_inv ? ~rx_word : rx_word;
    rx_bad   = ^{rx_word, rx_inv, rx_par};
    tx_inv   = ($countones(tx_word) < (W / 2));
    tx_coded = tx_inv ? ~tx_word : tx_word;
    tx_par   = ^{tx_coded, tx_inv};
  end

endmodule
`default_nettype wire

// File: verilog/host_bus_decode_parity.sv
/*
  Processor side front end of the memory hub: queues pipelined host
  requests, decodes their targets, decides snooping and aperture
  translation for inbound traffic, and handles bus parity and bus
  inversion. Assumes all bus inputs are already captured on the host
  clock by the source synchronous receivers, and that the consumers of
  the decoded requests sit on the same clock.
*/
// Behaviour
// - Coherent transfers use 64-byte lines
// - At most two processors, 100 MHz bus
// - Host and memory data rates run 1:1
// - Bus inversion applied and removed on data
// - Host addresses are 36 bits, 64 GB
// - Eight-entry in-order request queue
// - Address double pumped, data quad pumped
// - I/O claimed by graphics, wide hubs, config
// - Unclaimed I/O goes to south hub
// - Memory decode; unclaimed below 4 GB south
// - No snoop for graphics-native memory access
// - Snoop PCI-semantic graphics and hub accesses
// - Aperture accesses always get translated
// - Drive parity; check data and address parity
// - Data parity error sends enabled error message
// - Address parity error sends enabled message
// - No error phase; bad-parity requests complete
// - Response parity driven, never checked
// - Data moves at four transfers per clock
// - Full reset clears all logic
`timescale 1ns/1ns
`default_nettype none
module host_bus_decode_parity
  import host_bus_pkg::*;
#(
  parameter logic [35:0] MEM_LIMIT = MEM_TOP,   // Top of main memory
  parameter int          AGENTS    = MAX_AGENTS
)(
  input  wire logic              clock,
  input  wire logic              reset,           // Full reset input
  // Configuration of error reporting
  input  wire logic              cfg_write,
  input  wire logic              cfg_data_msg_en,
  input  wire logic              cfg_addr_msg_en,
  // Host request phase
  input  wire logic              req_valid,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic              req_is_io,
  input  wire logic [1:0]        host_addr_parity,
  output logic                   req_ready,
  // Decoded request towards the targets
  output logic                   out_valid,
  output logic [ADDR_W-1:0]      out_addr,
  output logic [2:0]             out_dest,
  output logic                   out_translate,
  input  wire logic              out_ready,
  // Host data received
  input  wire logic              rx_valid,
  input  wire logic [DATA_W-1:0] rx_data,
  input  wire logic [LANES-1:0]  rx_data_bus_inversion,
  input  wire logic [LANES-1:0]  host_data_parity,
  output logic                   rxd_valid,
  output logic [DATA_W-1:0]      rxd_data,
  // Host data driven
  input  wire logic              tx_valid,
  input  wire logic [DATA_W-1:0] tx_data,
  output logic                   txd_valid,
  output logic [DATA_W-1:0]      txd_data,
  output logic [LANES-1:0]       tx_data_bus_inversion,
  output logic [LANES-1:0]       tx_data_parity,
  // Response phase
  input  wire logic              rsp_valid,
  input  wire logic [2:0]        rsp_code,
  output logic                   rspd_valid,
  output logic [2:0]             rspd_code,
  output logic                   response_parity,
  // Inbound memory traffic from graphics port and hubs
  input  wire logic              inb_valid,
  input  wire logic [1:0]        inb_src,
  input  wire logic [ADDR_W-1:0] inb_addr,
  output logic                   inb_done,
  output logic                   inb_snoop,
  output logic                   inb_translate,
  // Error reporting
  output logic                   serr_message,
  output logic                   data_perr_seen,
  output logic                   addr_perr_seen
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (AGENTS < 1 || AGENTS > MAX_AGENTS)
  begin : g_bad_agents
    $error("at most two processor agents are served");
  end
  if (MEM_RATIO != 1 || BUS_MHZ != 100)
  begin : g_bad_rate
    $error("bus rate and memory ratio are fixed");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              data_en;      // Data parity message enable
    logic              addr_en;      // Address parity message enable
    logic              ov;           // Decoded request held
    logic [ADDR_W-1:0] oa;
    logic [2:0]        od;
    logic              ot;
    logic              rxv;          // Received data
    logic [DATA_W-1:0] rxd;
    logic              txv;          // Driven data
    logic [DATA_W-1:0] txd;
    logic [LANES-1:0]  txi;
    logic [LANES-1:0]  txp;
    logic              rv;           // Response
    logic [2:0]        rc;
    logic              rp;
    logic              iv;           // Inbound decision
    logic              isn;
    logic              itr;
    logic              serr;         // Error message pulse
    logic              dpe;          // Sticky data parity error
    logic              ape;          // Sticky address parity error
    logic              rdy;          // Queue has room
  } state_t;
  state_t s_q;
  state_t s_d;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic in_win36(input logic [35:0] a,
                                    input logic [35:0] lo,
                                    input logic [35:0] hi);
    in_win36 = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic in_win16(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_win16 = (a >= lo) && (a <= hi);
  endfunction

  // Target of a host request; positive claims first, then fallback
  function automatic dest_t decode(input logic [35:0] a,
                                   input logic        io);
    logic [15:0] p;
    p = a[15:0];
    if (io)
    begin
      if (in_win16(p, GFX_IO_BASE, GFX_IO_LIM))
        decode = DEST_GFX;
      else if (in_win16(p, HUBB_IO_BASE, HUBB_IO_LIM))
        decode = DEST_HUBB;
      else if (in_win16(p, HUBC_IO_BASE, HUBC_IO_LIM))
        decode = DEST_HUBC;
      else if (in_win16(p, CFG_IO_BASE, CFG_IO_LIM))
        decode = DEST_CFG;
      else
        decode = DEST_SOUTH;
    end
    else if (in_win36(a, APER_BASE, APER_LIM) || (a < MEM_LIMIT))
      decode = DEST_MEM;
    else if (in_win36(a, GFX_MEM_BASE, GFX_MEM_LIM))
      decode = DEST_GFX;
    else if (in_win36(a, HUBB_MEM_BASE, HUBB_MEM_LIM))
      decode = DEST_HUBB;
    else if (in_win36(a, HUBC_MEM_BASE, HUBC_MEM_LIM))
      decode = DEST_HUBC;
    else if (a < LIMIT_4G)
      decode = DEST_SOUTH;
    else
      decode = DEST_NONE;
  endfunction

  // ----------------------------------------------------------------
  // Request queue
  // ----------------------------------------------------------------
  logic               q_push;
  logic               q_pop;
  logic               q_empty;
  logic               q_full;
  logic [ENTRY_W-1:0] q_wdata;
  logic [ENTRY_W-1:0] q_rdata;
  logic [$clog2(IOQ_DEPTH):0] q_count;  // Queue occupancy
  logic [ADDR_W-1:0]  line_addr;
  dest_t              req_dest;

  // Requests are taken only while the registered ready is high
  assign line_addr = {req_addr[ADDR_W-1:LINE_LSB], LINE_LSB'(0)};
  assign req_dest  = decode(req_addr, req_is_io);
  assign q_push    = req_valid && s_q.rdy;
  assign q_pop     = !q_empty && (!s_q.ov || out_ready);
  assign q_wdata   = {req_is_io ? req_addr : line_addr,
                      req_dest,
                      !req_is_io && in_win36(req_addr, APER_BASE,
                                             APER_LIM)};

  ioq #(
    .WIDTH (ENTRY_W),
    .DEPTH (IOQ_DEPTH)
  ) u_ioq (
    .clock (clock),
    .reset (reset),
    .push  (q_push),
    .wdata (q_wdata),
    .pop   (q_pop),
    .rdata (q_rdata),
    .empty (q_empty),
    .full  (q_full),
    .count (q_count)
  );

  // ----------------------------------------------------------------
  // Data lanes
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] lane_plain;
  logic [DATA_W-1:0] lane_coded;
  logic [LANES-1:0]  lane_bad;
  logic [LANES-1:0]  lane_inv;
  logic [LANES-1:0]  lane_par;

  // One coder per parity lane; a beat carries all four lanes
  for (genvar i = 0; i < LANES; i++)
  begin : g_lane
    dbi_lane #(
      .W (LANE_W)
    ) u_lane (
      .rx_word  (rx_data[i*LANE_W +: LANE_W]),
      .rx_inv   (rx_data_bus_inversion[i]),
      .rx_par   (host_data_parity[i]),
      .tx_word  (tx_data[i*LANE_W +: LANE_W]),
      .rx_plain (lane_plain[i*LANE_W +: LANE_W]),
      .rx_bad   (lane_bad[i]),
      .tx_coded (lane_coded[i*LANE_W +: LANE_W]),
      .tx_inv   (lane_inv[i]),
      .tx_par   (lane_par[i])
    );
  end

  // ----------------------------------------------------------------
  // Parity checks on received groups
  // ----------------------------------------------------------------
  logic addr_bad;
  logic data_bad;
  // Both halves of the address are covered; response is never checked
  assign addr_bad = req_valid && s_q.rdy &&
                    ((^{req_addr[AP0_HI:AP0_LO], req_is_io,
                        host_addr_parity[0]}) ||
                     (^{req_addr[AP1_HI:AP1_LO],
                        host_addr_parity[1]}));
  assign data_bad = rx_valid && (|lane_bad);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    // Enables change only on an explicit configuration write
    if (cfg_write)
    begin
      s_d.data_en = cfg_data_msg_en;
      s_d.addr_en = cfg_addr_msg_en;
    end
    // Decoded request stage refills as soon as it empties
    if (q_pop)
    begin
      s_d.ov = 1'b1;
      {s_d.oa, s_d.od, s_d.ot} = q_rdata;
    end
    else if (out_ready)
      s_d.ov = 1'b0;
    // Room is judged one push ahead so a push never meets a full queue
    s_d.rdy = !q_full && !(q_push && (q_count ==
              ($clog2(IOQ_DEPTH)+1)'(IOQ_DEPTH - 1)));
    // Received beat with inversion removed
    s_d.rxv = rx_valid;
    s_d.rxd = lane_plain;
    // Driven beat with inversion and parity
    s_d.txv = tx_valid;
    s_d.txd = lane_coded;
    s_d.txi = lane_inv;
    s_d.txp = lane_par;
    // Response parity is driven every cycle, idle included
    s_d.rv  = rsp_valid;
    s_d.rc  = rsp_valid ? rsp_code : 3'h0;
    s_d.rp  = ^(rsp_valid ? rsp_code : 3'h0);
    // Inbound snoop and translation decision
    s_d.iv  = inb_valid;
    s_d.isn = inb_valid && (inb_src != 2'(SRC_GFX_NATIVE));
    s_d.itr = inb_valid && in_win36(inb_addr, APER_BASE, APER_LIM);
    // Errors are sticky; the message is a one-cycle pulse for each cycle with an enabled error
    s_d.dpe  = s_q.dpe || data_bad;
    s_d.ape  = s_q.ape || addr_bad;
    s_d.serr = (data_bad && s_q.data_en) ||
               (addr_bad && s_q.addr_en);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign req_ready             = s_q.rdy;
  assign out_valid             = s_q.ov;
  assign out_addr              = s_q.oa;
  assign out_dest              = s_q.od;
  assign out_translate         = s_q.ot;
  assign rxd_valid             = s_q.rxv;
  assign rxd_data              = s_q.rxd;
  assign txd_valid             = s_q.txv;
  assign txd_data              = s_q.txd;
  assign tx_data_bus_inversion = s_q.txi;
  assign tx_data_parity        = s_q.txp;
  assign rspd_valid            = s_q.rv;
  assign rspd_code             = s_q.rc;
  assign response_parity       = s_q.rp;
  assign inb_done              = s_q.iv;
  assign inb_snoop             = s_q.isn;
  assign inb_translate         = s_q.itr;
  assign serr_message          = s_q.serr;
  assign data_perr_seen        = s_q.dpe;
  assign addr_perr_seen        = s_q.ape;

endmodule
`default_nettype wire

// File: verilog/ioq.sv
/*
  In-order queue of pending host requests. Push and pop may share a
  cycle. Assumes the caller never pushes while full nor pops while empty.
*/
`timescale 1ns/1ns
`default_nettype none
module ioq
  import host_bus_pkg::*;
#(
  parameter int WIDTH = ENTRY_W,
  parameter int DEPTH = IOQ_DEPTH
)(
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             push,     // Store wdata
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic             pop,      // Retire the head
  output logic      [WIDTH-1:0] rdata,    // Head entry
  output logic                  empty,
  output logic                  full,
  output logic [$clog2(DEPTH):0] count
);

  localparam int PW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (DEPTH < 2 || (1 << PW) != DEPTH)
  begin : g_bad_depth
    $error("ioq depth must be a power of two");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;     // Entries
    logic [PW-1:0]               wp;      // Write pointer
    logic [PW-1:0]               rp;      // Read pointer
    logic [PW:0]                 cnt;     // Occupancy
  } ioq_state_t;

  ioq_state_t s_q;
  ioq_state_t s_d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_d = s_q;
    if (push)
    begin
      s_d.mem[s_q.wp] = wdata;
      s_d.wp          = s_q.wp + PW'(1);
    end
    if (pop)
    begin
      s_d.rp = s_q.rp + PW'(1);
    end
    // Occupancy follows push and pop together
    s_d.cnt = s_q.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.mem[s_q.rp];
  assign empty = (s_q.cnt == '0);
  assign full  = (s_q.cnt == (PW+1)'(DEPTH));
  assign count = s_q.cnt;

endmodule
`default_nettype wire
